//--- atxcs_pkg.sv
// package for the transmit control and status block
// assumes a 32-bit avalon-mm register bus on clk_sys
package atxcs_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  // ------------------------------------------------------------
  // control/status bit positions
  // ------------------------------------------------------------
  localparam int BIT_TX_EN = 31;
  localparam int BIT_SOFT_RESET = 24;
  localparam int BIT_WORD_START = 20;
  localparam int BIT_SYNC_ERR = 19;
  localparam int BIT_UNDERRUN = 18;
  localparam int BIT_EMPTY = 17;
  localparam int BIT_WS_IE = 12;
  localparam int BIT_SE_IE = 11;
  localparam int BIT_UR_IE = 10;
  localparam int BIT_EM_IE = 9;
  localparam int BIT_DMA_EN = 1;
  // ------------------------------------------------------------
  // clock config layout: 31:24 fields, 7:0 divider
  // ------------------------------------------------------------
  localparam logic [31:0] CLOCK_CONFIG_MASK = 32'hFF00_00FF;
  localparam logic [31:0] CLOCK_CONFIG_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_SRC_RESET = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // ------------------------------------------------------------
  // carried types
  // ------------------------------------------------------------
  typedef struct packed {
    logic sync_mode_hi;
    logic sync_mode_lo;
    logic clock_swap_sel;
    logic clock_from_pad;
    logic [1:0] master_clock_select;
    logic clock_polarity;
    logic clock_direction;
    logic [15:0] unused;
    logic [7:0] divider;
  } atxcs_clkcfg_t;
  // events from the serial engine, one-cycle pulses except empty
  typedef struct packed {
    logic word_start;
    logic sync_error;
    logic underrun;
    logic fifo_empty;
    logic frame_end;
  } atxcs_evt_t;
  typedef enum logic [1:0] {TX_OFF, TX_ON, TX_DRAIN} atxcs_state_t;
endpackage : atxcs_pkg

//--- atxcs_top.sv
// transmit control and status registers, interrupts and dma request
// assumes engine event inputs are synchronous to clk_sys
//
// Summary of operation
// - writing one to bit 24 pulses transmitter reset and clears status flags
// - clearing enable keeps transmitter on, reading one, until frame end
// - word start flag bit 20 set on word start, write one clears
// - sync error flag bit 19 set on frame sync error, write one clears
// - underrun flag bit 18 set on fifo underrun while transmitter active, write one clears
// - empty flag bit 17 follows enabled fifo empty level
// - bit 12 gates word start flag onto interrupt
// - bit 11 gates sync error flag onto interrupt
// - bit 10 gates underrun flag onto interrupt
// - bit 9 gates empty flag onto interrupt
// - dma request from empty only while bit 1 set
// - reserved control bits read zero, writes ignored
// - clock config layout 31:24 fields and divider low byte, reset zero
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module atxcs_top
  import atxcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire atxcs_pkg::atxcs_evt_t evt,
  output logic tx_active,
  output logic tx_soft_reset,
  output atxcs_pkg::atxcs_clkcfg_t clk_cfg,
  output logic dma_req,
  output logic irq
);
  import atxcs_pkg::*;

  // ------------------------------------------------------------
  // bus handshake: one wait cycle then answer
  // ------------------------------------------------------------
  logic ack_ff;
  logic req;
  logic wr_cs;
  logic wr_cc;
  logic rd_go;
  logic [31:0] wd;

  assign req = (avs_read | avs_write) & clk_en;
  assign avs_waitrequest = ~ack_ff;
  assign wd = avs_writedata;
  assign wr_cs = avs_write & ack_ff & (avs_address == ADDR_CTRL_STATUS);
  assign wr_cc = avs_write & ack_ff & (avs_address == ADDR_CLOCK_CONFIG);
  assign rd_go = avs_read & ack_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ------------------------------------------------------------
  // enable and drain state
  // ------------------------------------------------------------
  atxcs_state_t state_ff;
  atxcs_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TX_OFF: begin
        if (wr_cs && wd[BIT_TX_EN]) begin
          nxt_state = TX_ON;
        end
      end
      TX_ON: begin
        if (wr_cs && !wd[BIT_TX_EN]) begin
          nxt_state = evt.frame_end ? TX_OFF : TX_DRAIN;
        end
      end
      TX_DRAIN: begin
        if (wr_cs && wd[BIT_TX_EN]) begin
          nxt_state = TX_ON;
        end else if (evt.frame_end) begin
          nxt_state = TX_OFF;
        end
      end
      default: begin
        nxt_state = TX_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= TX_OFF;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign tx_active = (state_ff != TX_OFF);

  // ------------------------------------------------------------
  // soft reset pulse
  // ------------------------------------------------------------
  logic srst_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      srst_ff <= 1'b0;
    end else if (clk_en) begin
      srst_ff <= wr_cs & wd[BIT_SOFT_RESET];
    end
  end

  assign tx_soft_reset = srst_ff;

  // ------------------------------------------------------------
  // interrupt and dma enables
  // ------------------------------------------------------------
  logic [3:0] ie_ff;
  logic dma_en_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ie_ff <= IRQ_SRC_RESET;
      dma_en_ff <= 1'b0;
    end else if (clk_en && wr_cs) begin
      ie_ff <= {wd[BIT_WS_IE], wd[BIT_SE_IE], wd[BIT_UR_IE], wd[BIT_EM_IE]};
      dma_en_ff <= wd[BIT_DMA_EN];
    end
  end

  // ------------------------------------------------------------
  // sticky flags, set wins over write-one clear, soft reset clear wins over set
  // ------------------------------------------------------------
  logic [2:0] flag_ff;
  logic [2:0] evt_set;
  logic [2:0] w1c;
  logic empty_flag;

  assign evt_set = {evt.word_start, evt.sync_error, evt.underrun & tx_active};
  assign w1c = wr_cs ? {wd[BIT_WORD_START], wd[BIT_SYNC_ERR], wd[BIT_UNDERRUN]} : 3'h0;
  assign empty_flag = evt.fifo_empty & tx_active & ~srst_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_ff <= 3'h0;
    end else if (clk_en) begin
      if (srst_ff) begin
        flag_ff <= 3'h0;
      end else begin
        flag_ff <= evt_set | (flag_ff & ~w1c);
      end
    end
  end

  assign dma_req = empty_flag & dma_en_ff;

  // ------------------------------------------------------------
  // interrupt status register, cleared on read, and mask
  // ------------------------------------------------------------
  logic [3:0] src;
  logic [3:0] ist_ff;
  logic [3:0] imask_ff;
  logic rd_ist;

  assign src = {flag_ff, empty_flag} & ie_ff;
  assign rd_ist = rd_go & (avs_address == ADDR_IRQ_STATUS);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ist_ff <= IRQ_SRC_RESET;
    end else if (clk_en) begin
      ist_ff <= src | (rd_ist ? 4'h0 : ist_ff);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      imask_ff <= 4'hF;
    end else if (clk_en && avs_write && ack_ff && avs_address == ADDR_IRQ_MASK) begin
      imask_ff <= wd[3:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= (|(src & imask_ff)) | (|(ist_ff & imask_ff & ~{4{rd_ist}}));
    end
  end

  // ------------------------------------------------------------
  // clock configuration
  // ------------------------------------------------------------
  logic [31:0] clkcfg_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clkcfg_ff <= CLOCK_CONFIG_RESET;
    end else if (clk_en && wr_cc) begin
      clkcfg_ff <= wd & CLOCK_CONFIG_MASK;
    end
  end

  assign clk_cfg = atxcs_clkcfg_t'(clkcfg_ff);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] cs_rd;

  always_comb begin
    cs_rd = READ_ZERO;
    cs_rd[BIT_TX_EN] = tx_active;
    cs_rd[BIT_WORD_START] = flag_ff[2];
    cs_rd[BIT_SYNC_ERR] = flag_ff[1];
    cs_rd[BIT_UNDERRUN] = flag_ff[0];
    cs_rd[BIT_EMPTY] = empty_flag;
    cs_rd[BIT_WS_IE] = ie_ff[3];
    cs_rd[BIT_SE_IE] = ie_ff[2];
    cs_rd[BIT_UR_IE] = ie_ff[1];
    cs_rd[BIT_EM_IE] = ie_ff[0];
    cs_rd[BIT_DMA_EN] = dma_en_ff;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_readdata <= READ_ZERO;
    end else if (clk_en && req && !ack_ff) begin
      case (avs_address)
        ADDR_CTRL_STATUS: avs_readdata <= cs_rd;
        ADDR_CLOCK_CONFIG: avs_readdata <= clkcfg_ff;
        ADDR_IRQ_STATUS: avs_readdata <= {28'h000_0000, ist_ff};
        ADDR_IRQ_MASK: avs_readdata <= {28'h000_0000, imask_ff};
        default: avs_readdata <= READ_ZERO;
      endcase
    end
  end
endmodule : atxcs_top

//--- atxcs_sva.sv
// port checker for atxcs_top
// assumes a bind to atxcs_top, one clock domain
`timescale 1ns/1ns
module atxcs_sva
  import atxcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire atxcs_pkg::atxcs_evt_t evt,
  input wire logic tx_active,
  input wire logic tx_soft_reset,
  input wire atxcs_pkg::atxcs_clkcfg_t clk_cfg,
  input wire logic dma_req,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic rd_ok, sr_req, cfg_wr;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign sr_req = avs_write && !avs_waitrequest && clk_en && avs_address == ADDR_CTRL_STATUS
    && avs_writedata[BIT_SOFT_RESET];
  assign cfg_wr = avs_write && !avs_waitrequest && clk_en && avs_address == ADDR_CLOCK_CONFIG;
  AST_SR_PULSE:
    assert property (sr_req |=> tx_soft_reset ##1 !tx_soft_reset) else $error("reset pulse");
  AST_SR_CAUSE:
    assert property ($rose(tx_soft_reset) |-> $past(sr_req)) else $error("stray reset");
  AST_DRAIN:
    assert property ($fell(tx_active) |-> $past(evt.frame_end) || $past(evt.frame_end, 2))
      else $error("early stop");
  AST_DMA:
    assert property (dma_req |-> evt.fifo_empty && tx_active) else $error("dma request");
  AST_CTRL_RSVD:
    assert property (rd_ok && avs_address == ADDR_CTRL_STATUS
      |-> (avs_readdata & 32'h01E1_E1FD) == READ_ZERO) else $error("reserved bits");
  AST_CFG_RSVD:
    assert property (rd_ok && avs_address == ADDR_CLOCK_CONFIG
      |-> (avs_readdata & ~CLOCK_CONFIG_MASK) == READ_ZERO) else $error("config bits");
  AST_CFG_WR:
    assert property (cfg_wr |=> clk_cfg == ($past(avs_writedata) & CLOCK_CONFIG_MASK))
      else $error("config write");
  AST_CFG_HOLD:
    assert property (!cfg_wr |=> $stable(clk_cfg)) else $error("config moved");
  AST_ONE_WAIT:
    assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
      else $error("wait state count");
endmodule : atxcs_sva

//--- atxcs_engine_model.sv
// event source standing in for the serial engine
// assumes fire bits are one-cycle requests on clk_sys
`timescale 1ns/1ns
module atxcs_engine_model
  import atxcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [3:0] fire,
  input wire logic empty,
  output atxcs_pkg::atxcs_evt_t evt
);
  // fire: word start, sync error, underrun, frame end
  always_ff @(posedge clk_sys) begin
    evt <= {fire[3:1], empty, fire[0]};
  end
endmodule : atxcs_engine_model

//--- tb_top.sv
// self-checking bench for atxcs_top
// assumes the engine model supplies events on clk_sys
`timescale 1ns/1ns
module tb_top;
  import atxcs_pkg::*;
  typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] e;} atxcs_row_t;
  logic clk_sys = 0, reset = 1, clk_en = 1, avs_read = 0, avs_write = 0, empty = 0;
  logic [3:0] avs_address = 4'h0, fire = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic avs_waitrequest, tx_active, tx_soft_reset, dma_req, irq;
  atxcs_evt_t evt;
  atxcs_clkcfg_t clk_cfg;
  int error_cnt = 0, samples_checked = 0;
  atxcs_row_t rows[5] = '{'{4'h8, 32'hFFFF_FFFF, 32'hFF00_00FF},
    '{4'h8, 32'h5A00_00A5, 32'h5A00_00A5}, '{4'h0, 32'h00FF_FFFF, 32'h0000_1E02},
    '{4'h2, 32'hFFFF_FFFF, 32'h0000_0000}, '{4'hC, 32'h0000_0005, 32'h0000_0005}};
  `define CHK(x, y) begin samples_checked++; if ((x) !== (y)) begin error_cnt++; \
    $display("[FAIL] %0t %h %h", $time, x, y); end end
  atxcs_top atxcs_top_inst (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt(evt), .tx_active(tx_active),
    .tx_soft_reset(tx_soft_reset), .clk_cfg(clk_cfg), .dma_req(dma_req), .irq(irq));
  atxcs_engine_model atxcs_engine_model_inst (.clk_sys(clk_sys), .fire(fire), .empty(empty),
    .evt(evt));
  always #2 clk_sys = ~clk_sys;
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask : chk_rd
  task automatic pulse(input logic [3:0] f, input logic e);
    @(posedge clk_sys);
    fire <= f;
    empty <= e;
    @(posedge clk_sys);
    fire <= 4'h0;
    repeat (3) @(negedge clk_sys);
  endtask : pulse
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'h0;
    chk_rd(4'h8, 32'h0000_0000);
    chk_rd(4'hC, 32'h0000_000F);
    chk_rd(4'h0, 32'h0000_0000);
    foreach (rows[i]) begin
      bus(1'h1, rows[i].a, rows[i].d);
      chk_rd(rows[i].a, rows[i].e);
    end
    `CHK(clk_cfg, 32'h5A00_00A5)
    bus(1'h1, 4'hC, 32'h0000_000F);
    bus(1'h1, 4'h0, 32'h8000_1E02);
    for (int k = 1; k < 4; k++) begin
      pulse(4'h1 << k, 1'h0);
      chk_rd(4'h0, 32'h8000_1E02 | (32'h1 << (17 + k)));
      `CHK(irq, 1'h1)
      bus(1'h1, 4'h0, 32'h8000_1E02 | (32'h1 << (17 + k)));
      chk_rd(4'h4, 32'h1 << k);
      chk_rd(4'h4, 32'h0000_0000);
      pulse(4'h0, 1'h0);
      `CHK(irq, 1'h0)
    end
    chk_rd(4'h0, 32'h8000_1E02);
    clk_en <= 1'h0;
    pulse(4'h8, 1'h0);
    @(posedge clk_sys);
    clk_en <= 1'h1;
    chk_rd(4'h0, 32'h8000_1E02);
    `CHK(irq, 1'h0)
    bus(1'h1, 4'h0, 32'h8000_0002);
    pulse(4'h8, 1'h1);
    `CHK(irq, 1'h0)
    chk_rd(4'h0, 32'h8012_0002);
    `CHK(dma_req, 1'h1)
    bus(1'h1, 4'h0, 32'h8000_0200);
    pulse(4'h0, 1'h1);
    `CHK(dma_req, 1'h0)
    `CHK(irq, 1'h1)
    bus(1'h1, 4'h0, 32'h8100_0000);
    pulse(4'h0, 1'h0);
    chk_rd(4'h0, 32'h8000_0000);
    bus(1'h1, 4'h0, 32'h0000_0000);
    chk_rd(4'h0, 32'h8000_0000);
    pulse(4'h1, 1'h0);
    chk_rd(4'h0, 32'h0000_0000);
    `CHK(tx_active, 1'h0)
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    `CHK(irq, 1'h0)
    `CHK(clk_cfg, 32'h0000_0000)
    chk_rd(4'h8, 32'h0000_0000);
    chk_rd(4'hC, 32'h0000_000F);
    end_of_test();
  end
endmodule : tb_top
bind atxcs_top atxcs_sva atxcs_sva_inst (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .evt(evt), .tx_active(tx_active),
  .tx_soft_reset(tx_soft_reset), .clk_cfg(clk_cfg), .dma_req(dma_req), .irq(irq));
